//--- logic/dpa_map.vh
// Behaviour
// - Secondary menu closes after 30 idle seconds
// - Secure menu closes after 60 idle seconds
// - Secure menu forces pumps and alarms off
// - Home shows level and lead on; errors first
// - Codes 1101, 1011, 111 select levels 2-4
// - Access item writable at any level
// - Valid code blinks, then shows new level
// - Edits clamp to thresholds and scale silently
// - Independent mode: pair per pump
// - Alternating: first on starts one pump
// - Second on runs both; second off drops one
// - First off stops remaining pump
// - Alternating, no overheat or latched seal: last stopped pump never starts next
// - Pump lamp lit while pump runs
// - Seal fault when resistance below threshold
// - Auto seal mode: lamp follows fault only
// - Latched seal, no alternation: lamp latches only
// - Latched seal, alternating: failed pump becomes lag
// - Seal reset clears only when fault gone
// - Open thermostat removes pump, lights lamp
// - Over-temperature: healthy pump leads or pair one
// - Over-temperature auto restore or latched reset
`ifndef DPA_MAP_VH
`define DPA_MAP_VH

`define DPA_CLK_HZ 200000000
`define DPA_TICK_S 1
`define DPA_SECONDARY_TIMEOUT_S 6'h1E
`define DPA_SECURE_TIMEOUT_S 6'h3C
`define DPA_BLINK_S 2'h1

`define DPA_CODE_LEVEL2 16'h1101
`define DPA_CODE_LEVEL3 16'h1011
`define DPA_CODE_LEVEL4 16'h0111
`define DPA_LEVEL2 3'h2
`define DPA_LEVEL3 3'h3
`define DPA_LEVEL4 3'h4
`define DPA_LEVEL_RESET 3'h4

`define DPA_SEL_LEAD_ON 3'h0
`define DPA_SEL_LEAD_OFF 3'h1
`define DPA_SEL_SECOND_ON 3'h2
`define DPA_SEL_SECOND_OFF 3'h3
`define DPA_SEL_ALARM_HIGH 3'h4
`define DPA_SEL_ALARM_LOW 3'h5
`define DPA_SEL_MOIST_ONE 3'h6
`define DPA_SEL_MOIST_TWO 3'h7

`define DPA_ON_LEVEL_RESET 16'h00E7
`define DPA_OFF_LEVEL_RESET 16'h0000
`define DPA_ALARM_HIGH_RESET 16'h00E7
`define DPA_ALARM_LOW_RESET 16'h0014
`define DPA_MOIST_RESET 16'h000C
`define DPA_MOIST_MIN 16'h0001
`define DPA_MOIST_MAX 16'h0032

`define DPA_DISP_HOME 3'h0
`define DPA_DISP_ERROR 3'h1
`define DPA_DISP_MENU 3'h2
`define DPA_DISP_BLINK 3'h3
`define DPA_DISP_LEVEL 3'h4

`endif

//--- logic/dpa_sync.v
module dpa_sync #(
  parameter W = 1
) (
  input wire i_mclk,
  input wire i_rst_n,
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);

  reg [W-1:0] stage1;
  reg [W-1:0] stage2;
  reg [W-1:0] stage3;
  integer k;

  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      stage1 <= {W{1'b0}};
      stage2 <= {W{1'b0}};
      stage3 <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end
    else
    begin
      stage1 <= i_async;
      stage2 <= stage1;
      stage3 <= stage2;
      // Accept a change only once the last two stages agree
      for (k = 0; k < W; k = k + 1)
      begin
        if (stage2[k] == stage3[k])
          o_sync[k] <= stage3[k];
      end
    end
  end

endmodule // dpa_sync

//--- logic/dpa_core.v
`include "dpa_map.vh"

module dpa_core #(
  parameter TICK_CYCLES = `DPA_CLK_HZ * `DPA_TICK_S
) (
  input wire i_mclk,
  input wire i_rst_n,
  input wire [3:0] i_keys,
  input wire [1:0] i_thermo_closed,
  input wire signed [15:0] i_level,
  input wire [15:0] i_moisture_one,
  input wire [15:0] i_moisture_two,
  input wire signed [15:0] i_scale_low,
  input wire signed [15:0] i_scale_high,
  input wire i_alternation_enable,
  input wire i_seal_fault_action,
  input wire i_overheat_action,
  input wire i_error_active,
  input wire i_open_secondary,
  input wire i_open_secure,
  input wire i_menu_exit,
  input wire [2:0] i_edit_sel,
  input wire signed [15:0] i_edit_value,
  input wire i_edit_store,
  input wire [15:0] i_access_code,
  input wire i_access_store,
  input wire i_pump_one_seal_reset,
  input wire i_pump_two_seal_reset,
  input wire i_pump_one_overheat_reset,
  input wire i_pump_two_overheat_reset,
  output reg o_pump_one,
  output reg o_pump_two,
  output reg o_first_pump_lamp,
  output reg o_second_pump_lamp,
  output reg o_alarm_high,
  output reg o_alarm_low,
  output reg [1:0] o_seal_lamp,
  output reg [1:0] o_overheat_lamp,
  output reg [1:0] o_seal_fail_show,
  output reg [1:0] o_overheat_fail_show,
  output reg [2:0] o_access_level_item,
  output reg [2:0] o_menu_state,
  output reg [2:0] o_disp_src,
  output reg signed [15:0] o_disp_upper,
  output reg signed [15:0] o_disp_lower,
  output reg signed [15:0] o_edit_readback
);

  localparam ST_HOME = 3'b001;
  localparam ST_SECONDARY = 3'b010;
  localparam ST_SECURE = 3'b100;

  function signed [15:0] dpa_clamp;
    input signed [15:0] v;
    input signed [15:0] lo;
    input signed [15:0] hi;
    begin
      if (v < lo)
        dpa_clamp = lo;
      else if (v > hi)
        dpa_clamp = hi;
      else
        dpa_clamp = v;
    end
  endfunction

  wire [3:0] keys_s;
  wire [1:0] thermo_open_s;

  dpa_sync #(.W(4)) u_key_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async(i_keys),
    .o_sync(keys_s)
  );

  dpa_sync #(.W(2)) u_thermo_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async(~i_thermo_closed),
    .o_sync(thermo_open_s)
  );

  reg [3:0] keys_prev;
  reg [27:0] presc;
  reg [5:0] idle_s;
  reg [2:0] menu;
  reg [2:0] next_menu;
  reg [2:0] level_sel;
  reg [1:0] blink_s;
  reg blinking;
  reg show_level;
  reg signed [15:0] lead_on_level;
  reg signed [15:0] lead_off_level;
  reg signed [15:0] second_on_level;
  reg signed [15:0] second_off_level;
  reg signed [15:0] alarm_high_level;
  reg signed [15:0] alarm_low_level;
  reg [15:0] pump_one_moisture_threshold;
  reg [15:0] pump_two_moisture_threshold;
  reg [1:0] seal_latch;
  reg [1:0] heat_latch;
  reg stage1;
  reg stage2;
  reg lead;
  reg last_stop;
  reg [1:0] run;
  reg next_lead;
  reg [1:0] next_run;
  reg forced;
  reg forced_lead;
  reg [15:0] code_level;

  wire key_press = |(keys_s & ~keys_prev);
  wire activity = key_press | i_edit_store | i_access_store | i_open_secondary | i_open_secure;
  wire tick = (presc == TICK_CYCLES[27:0] - 28'h0000001);
  wire [1:0] seal_raw;
  // Open contacts synced; idle low, so reset shows no fault
  wire [1:0] heat_raw = thermo_open_s;
  wire [1:0] seal_reset = {i_pump_two_seal_reset, i_pump_one_seal_reset};
  wire [1:0] heat_reset = {i_pump_two_overheat_reset, i_pump_one_overheat_reset};
  wire [1:0] seal_fault;
  wire [1:0] heat_fault;
  wire [1:0] avail;
  wire secure_open = (menu == ST_SECURE);
  wire code_valid = (i_access_code == `DPA_CODE_LEVEL2) | (i_access_code == `DPA_CODE_LEVEL3) |
    (i_access_code == `DPA_CODE_LEVEL4);
  wire next_stage1 = stage1 ? (i_level > lead_off_level) : (i_level >= lead_on_level);
  wire next_stage2 = stage2 ? (i_level > second_off_level) : (i_level >= second_on_level);

  assign seal_raw[0] = (i_moisture_one < pump_one_moisture_threshold);
  assign seal_raw[1] = (i_moisture_two < pump_two_moisture_threshold);
  assign seal_fault = i_seal_fault_action ? seal_latch : seal_raw;
  assign heat_fault = i_overheat_action ? heat_latch : heat_raw;
  assign avail = ~heat_fault;

  always @*
  begin
    code_level = 16'h0000;
    case (i_access_code)
      `DPA_CODE_LEVEL2: code_level = {13'h0000, `DPA_LEVEL2};
      `DPA_CODE_LEVEL3: code_level = {13'h0000, `DPA_LEVEL3};
      `DPA_CODE_LEVEL4: code_level = {13'h0000, `DPA_LEVEL4};
      default: code_level = {13'h0000, level_sel};
    endcase
  end

  // Menu timeouts
  always @*
  begin
    next_menu = menu;
    case (menu)
      ST_HOME:
      begin
        if (i_open_secure)
          next_menu = ST_SECURE;
        else if (i_open_secondary)
          next_menu = ST_SECONDARY;
      end
      ST_SECONDARY:
      begin
        if (i_menu_exit || (idle_s >= `DPA_SECONDARY_TIMEOUT_S))
          next_menu = ST_HOME;
      end
      ST_SECURE:
      begin
        if (i_menu_exit || (idle_s >= `DPA_SECURE_TIMEOUT_S))
          next_menu = ST_HOME;
      end
      default: next_menu = ST_HOME;
    endcase
  end

  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      keys_prev <= 4'h0;
      presc <= 28'h0000000;
      idle_s <= 6'h00;
      menu <= ST_HOME;
    end
    else
    begin
      keys_prev <= keys_s;
      if (activity || menu == ST_HOME)
      begin
        presc <= 28'h0000000;
        idle_s <= 6'h00;
      end
      else if (tick)
      begin
        presc <= 28'h0000000;
        if (idle_s != 6'h3F)
          idle_s <= idle_s + 6'h01;
      end
      else
        presc <= presc + 28'h0000001;
      menu <= next_menu;
    end
  end

  // Access level, blink and level display
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      level_sel <= `DPA_LEVEL_RESET;
      blink_s <= 2'h0;
      blinking <= 1'b0;
      show_level <= 1'b0;
    end
    else
    begin
      if (i_access_store && code_valid && menu != ST_HOME)
      begin
        level_sel <= code_level[2:0];
        blinking <= 1'b1;
        blink_s <= 2'h0;
        show_level <= 1'b0;
      end
      else if (blinking)
      begin
        if (next_menu == ST_HOME)
          blinking <= 1'b0;
        else if (tick)
        begin
          if (blink_s + 2'h1 >= `DPA_BLINK_S)
          begin
            blinking <= 1'b0;
            show_level <= 1'b1;
          end
          blink_s <= blink_s + 2'h1;
        end
      end
      else if (key_press || i_edit_store || next_menu == ST_HOME)
        show_level <= 1'b0;
    end
  end

  // Set point editing with silent clamping
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      lead_on_level <= `DPA_ON_LEVEL_RESET;
      lead_off_level <= `DPA_OFF_LEVEL_RESET;
      second_on_level <= `DPA_ON_LEVEL_RESET;
      second_off_level <= `DPA_OFF_LEVEL_RESET;
      alarm_high_level <= `DPA_ALARM_HIGH_RESET;
      alarm_low_level <= `DPA_ALARM_LOW_RESET;
      pump_one_moisture_threshold <= `DPA_MOIST_RESET;
      pump_two_moisture_threshold <= `DPA_MOIST_RESET;
    end
    else if (i_edit_store && menu == ST_SECONDARY && level_sel != `DPA_LEVEL2)
    begin
      case (i_edit_sel)
        `DPA_SEL_LEAD_ON: lead_on_level <= dpa_clamp(i_edit_value, lead_off_level, i_scale_high);
        `DPA_SEL_LEAD_OFF: lead_off_level <= dpa_clamp(i_edit_value, i_scale_low, lead_on_level);
        `DPA_SEL_SECOND_ON: second_on_level <= dpa_clamp(i_edit_value, second_off_level, i_scale_high);
        `DPA_SEL_SECOND_OFF: second_off_level <= dpa_clamp(i_edit_value, i_scale_low, second_on_level);
        `DPA_SEL_ALARM_HIGH: alarm_high_level <= dpa_clamp(i_edit_value, i_scale_low, i_scale_high);
        `DPA_SEL_ALARM_LOW: alarm_low_level <= dpa_clamp(i_edit_value, i_scale_low, i_scale_high);
        `DPA_SEL_MOIST_ONE: pump_one_moisture_threshold <= dpa_clamp(i_edit_value, `DPA_MOIST_MIN, `DPA_MOIST_MAX);
        default: pump_two_moisture_threshold <= dpa_clamp(i_edit_value, `DPA_MOIST_MIN, `DPA_MOIST_MAX);
      endcase
    end
  end

  // Fault latches; a new fault wins over a reset, auto mode follows the raw fault
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      seal_latch <= 2'h0;
      heat_latch <= 2'h0;
    end
    else
    begin
      seal_latch <= seal_raw | (seal_latch & ~seal_reset & {2{i_seal_fault_action}});
      heat_latch <= heat_raw | (heat_latch & ~heat_reset & {2{i_overheat_action}});
    end
  end

  // Pump selection
  always @*
  begin
    forced = 1'b0;
    forced_lead = lead;
    if (heat_fault == 2'b01)
    begin
      forced = 1'b1;
      forced_lead = 1'b1;
    end
    else if (heat_fault == 2'b10)
    begin
      forced = 1'b1;
      forced_lead = 1'b0;
    end
    else if (i_seal_fault_action && seal_latch == 2'b01)
    begin
      forced = 1'b1;
      forced_lead = 1'b1;
    end
    else if (i_seal_fault_action && seal_latch == 2'b10)
    begin
      forced = 1'b1;
      forced_lead = 1'b0;
    end
    next_lead = lead;
    if (forced)
      next_lead = forced_lead;
    else if (next_stage1 && run == 2'b00)
      next_lead = ~last_stop;
    next_run = 2'b00;
    if (i_alternation_enable)
    begin
      if (next_stage2)
        next_run = 2'b11;
      else if (next_stage1)
        next_run = next_lead ? 2'b10 : 2'b01;
      else
        next_run = 2'b00;
    end
    else
    begin
      next_run[0] = next_stage1;
      next_run[1] = heat_fault[0] ? next_stage1 : next_stage2;
    end
    next_run = next_run & avail;
  end

  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      lead <= 1'b0;
      last_stop <= 1'b0;
      run <= 2'b00;
    end
    else
    begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
      lead <= next_lead;
      run <= next_run;
      if (run != 2'b00 && next_run == 2'b00)
      begin
        if (run == 2'b01)
          last_stop <= 1'b0;
        else if (run == 2'b10)
          last_stop <= 1'b1;
        else
          last_stop <= lead;
      end
    end
  end

  // Registered outputs
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_pump_one <= 1'b0;
      o_pump_two <= 1'b0;
      o_first_pump_lamp <= 1'b0;
      o_second_pump_lamp <= 1'b0;
      o_alarm_high <= 1'b0;
      o_alarm_low <= 1'b0;
      o_seal_lamp <= 2'h0;
      o_overheat_lamp <= 2'h0;
      o_seal_fail_show <= 2'h0;
      o_overheat_fail_show <= 2'h0;
      o_access_level_item <= `DPA_LEVEL_RESET;
      o_menu_state <= ST_HOME;
      o_disp_src <= `DPA_DISP_HOME;
      o_disp_upper <= 16'h0000;
      o_disp_lower <= 16'h0000;
      o_edit_readback <= 16'h0000;
    end
    else
    begin
      o_pump_one <= next_run[0] & ~secure_open;
      o_pump_two <= next_run[1] & ~secure_open;
      o_first_pump_lamp <= next_run[0] & ~secure_open;
      o_second_pump_lamp <= next_run[1] & ~secure_open;
      o_alarm_high <= (i_level >= alarm_high_level) & ~secure_open;
      o_alarm_low <= (i_level <= alarm_low_level) & ~secure_open;
      o_seal_lamp <= seal_fault;
      o_overheat_lamp <= heat_fault;
      o_seal_fail_show <= seal_latch & {2{i_seal_fault_action}};
      o_overheat_fail_show <= heat_latch & {2{i_overheat_action}};
      o_access_level_item <= level_sel;
      o_menu_state <= menu;
      o_disp_lower <= lead_on_level;
      if (blinking)
      begin
        o_disp_src <= `DPA_DISP_BLINK;
        o_disp_upper <= {13'h0000, level_sel};
      end
      else if (show_level)
      begin
        o_disp_src <= `DPA_DISP_LEVEL;
        o_disp_upper <= {13'h0000, level_sel};
      end
      else if (menu != ST_HOME)
      begin
        o_disp_src <= `DPA_DISP_MENU;
        o_disp_upper <= i_level;
      end
      else if (i_error_active)
      begin
        o_disp_src <= `DPA_DISP_ERROR;
        o_disp_upper <= i_level;
      end
      else
      begin
        o_disp_src <= `DPA_DISP_HOME;
        o_disp_upper <= i_level;
      end
      case (i_edit_sel)
        `DPA_SEL_LEAD_ON: o_edit_readback <= lead_on_level;
        `DPA_SEL_LEAD_OFF: o_edit_readback <= lead_off_level;
        `DPA_SEL_SECOND_ON: o_edit_readback <= second_on_level;
        `DPA_SEL_SECOND_OFF: o_edit_readback <= second_off_level;
        `DPA_SEL_ALARM_HIGH: o_edit_readback <= alarm_high_level;
        `DPA_SEL_ALARM_LOW: o_edit_readback <= alarm_low_level;
        `DPA_SEL_MOIST_ONE: o_edit_readback <= pump_one_moisture_threshold;
        default: o_edit_readback <= pump_two_moisture_threshold;
      endcase
    end
  end

endmodule // dpa_core

//--- verification/dpa_core_asserts.sv
module dpa_core_asserts #(
  parameter longint TICK_CYCLES = 200000000
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_keys,
  input wire logic [1:0] i_thermo_closed,
  input wire logic signed [15:0] i_level,
  input wire logic i_alternation_enable,
  input wire logic i_error_active,
  input wire logic i_open_secondary,
  input wire logic i_open_secure,
  input wire logic i_menu_exit,
  input wire logic i_edit_store,
  input wire logic [15:0] i_access_code,
  input wire logic i_access_store,
  input wire logic o_pump_one,
  input wire logic o_pump_two,
  input wire logic o_first_pump_lamp,
  input wire logic o_second_pump_lamp,
  input wire logic o_alarm_high,
  input wire logic o_alarm_low,
  input wire logic [1:0] o_seal_lamp,
  input wire logic [1:0] o_overheat_lamp,
  input wire logic [2:0] o_access_level_item,
  input wire logic [2:0] o_menu_state,
  input wire logic [2:0] o_disp_src,
  input wire logic signed [15:0] o_disp_upper
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  logic [39:0] idle;
  logic [3:0] keys_q;
  logic last_two;
  // Idle cycles in a menu; last pump stopped alone while alternating
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      idle <= 40'h0;
      keys_q <= 4'h0;
      last_two <= 1'b0;
    end
    else
    begin
      keys_q <= i_keys;
      if (o_menu_state == 3'h1 || (i_keys & ~keys_q) != 4'h0 || i_edit_store || i_access_store
          || i_open_secondary || i_open_secure)
        idle <= 40'h0;
      else
        idle <= idle + 40'h1;
      if (i_alternation_enable && $fell(o_pump_one) && !$fell(o_pump_two))
        last_two <= 1'b0;
      else if (i_alternation_enable && $fell(o_pump_two) && !$fell(o_pump_one))
        last_two <= 1'b1;
    end
  end
  sequence s_valid_code;
    i_access_store && o_menu_state != 3'h1
      && (i_access_code == 16'h1101 || i_access_code == 16'h1011 || i_access_code == 16'h0111);
  endsequence
  a_lamps_follow_pumps: assert property (o_first_pump_lamp == o_pump_one && o_second_pump_lamp == o_pump_two)
    else $error("pump lamp differs from pump output");
  a_secure_forces_off: assert property (o_menu_state == 3'h4 && $past(o_menu_state) == 3'h4 |->
    !o_pump_one && !o_pump_two && !o_alarm_high && !o_alarm_low)
    else $error("output active in secure menu");
  a_menu_idle_late: assert property (o_menu_state != 3'h1 |->
    idle < (o_menu_state == 3'h4 ? 60 : 30) * TICK_CYCLES + 8)
    else $error("menu stayed open too long");
  a_menu_idle_early: assert property (o_menu_state == 3'h1 && $past(o_menu_state) != 3'h1
    && !$past(i_menu_exit, 2) |->
    idle + 8 >= ($past(o_menu_state) == 3'h4 ? 60 : 30) * TICK_CYCLES)
    else $error("menu closed too early");
  a_home_shows_level: assert property ($past(i_rst_n) && o_menu_state == 3'h1 && $past(o_menu_state) == 3'h1
    && !$past(i_error_active) |-> o_disp_src == 3'h0 && o_disp_upper == $past(i_level))
    else $error("home display wrong");
  a_error_has_priority: assert property ($past(i_error_active) && o_menu_state == 3'h1
    && $past(o_menu_state) == 3'h1 |-> o_disp_src == 3'h1)
    else $error("error not shown at home");
  a_code_sets_level: assert property (s_valid_code |-> ##2 o_access_level_item ==
    ($past(i_access_code, 2) == 16'h1101 ? 3'h2 : $past(i_access_code, 2) == 16'h1011 ? 3'h3 : 3'h4))
    else $error("access level wrong after code");
  a_code_blinks: assert property (s_valid_code |-> ##2 o_disp_src == 3'h3)
    else $error("no blink after code");
  a_overheat_stops: assert property (!i_thermo_closed[0] [*6] |=>
    !o_pump_one && (o_overheat_lamp[0] || o_menu_state == 3'h4))
    else $error("overheated pump one still in service");
  a_alt_not_last_one: assert property ($rose(o_pump_one) && !o_pump_two && !$past(o_pump_two)
    && i_alternation_enable && &i_thermo_closed && o_seal_lamp == 2'h0 |-> last_two)
    else $error("pump one restarted after stopping last");
  a_alt_not_last_two: assert property ($rose(o_pump_two) && !o_pump_one && !$past(o_pump_one)
    && i_alternation_enable && &i_thermo_closed && o_seal_lamp == 2'h0 |-> !last_two)
    else $error("pump two restarted after stopping last");
  c_lone_start: cover property ($rose(o_pump_two) && !o_pump_one);
  c_secure_open: cover property (o_menu_state == 3'h4);
  c_blink_seen: cover property (o_disp_src == 3'h3);
endmodule // dpa_core_asserts

bind dpa_core dpa_core_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_dpa_core_asserts (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_keys(i_keys), .i_thermo_closed(i_thermo_closed), .i_level(i_level),
  .i_alternation_enable(i_alternation_enable), .i_error_active(i_error_active),
  .i_open_secondary(i_open_secondary), .i_open_secure(i_open_secure), .i_menu_exit(i_menu_exit),
  .i_edit_store(i_edit_store),
  .i_access_code(i_access_code), .i_access_store(i_access_store), .o_pump_one(o_pump_one),
  .o_pump_two(o_pump_two), .o_first_pump_lamp(o_first_pump_lamp), .o_second_pump_lamp(o_second_pump_lamp),
  .o_alarm_high(o_alarm_high), .o_alarm_low(o_alarm_low), .o_seal_lamp(o_seal_lamp),
  .o_overheat_lamp(o_overheat_lamp), .o_access_level_item(o_access_level_item),
  .o_menu_state(o_menu_state), .o_disp_src(o_disp_src), .o_disp_upper(o_disp_upper));

//--- verification/dpa_plant.sv
module dpa_plant (
  output logic signed [15:0] o_level,
  output logic [1:0] o_thermo_closed,
  output logic [15:0] o_moisture_one,
  output logic [15:0] o_moisture_two
);
  timeunit 1ns;
  timeprecision 1ps;
  // Dry probes, cool pumps, low level
  initial
  begin
    o_level = 16'sh0028;
    o_thermo_closed = 2'h3;
    o_moisture_one = 16'h0014;
    o_moisture_two = 16'h0014;
  end
  task set_level(input logic signed [15:0] v);
    o_level = v;
  endtask
  task set_thermo(input logic [1:0] v);
    o_thermo_closed = v;
  endtask
  task set_moisture(input logic [15:0] one, input logic [15:0] two);
    o_moisture_one = one;
    o_moisture_two = two;
  endtask
endmodule // dpa_plant

//--- verification/dpa_core_tb.sv
module dpa_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 20;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] keys = 4'h0;
  logic alt = 1'b1, sfa = 1'b0, ofa = 1'b0, err = 1'b0, osec = 1'b0, osecu = 1'b0;
  logic est = 1'b0, ast = 1'b0, sr1 = 1'b0, sr2 = 1'b0, or1 = 1'b0, or2 = 1'b0, mex = 1'b0;
  logic signed [15:0] slo = 16'sh0000, shi = 16'sh012C;
  logic [2:0] sel = 3'h0;
  logic [15:0] val = 16'h0000, code = 16'h0000;
  wire signed [15:0] lvl, du, dl, rb;
  wire [15:0] m1, m2;
  wire [1:0] th, sl, ol, ss, os;
  wire [2:0] lv, ms, ds;
  wire p1, p2, l1, l2, ah, al;
  int n_errors = 0;
  int n_compared = 0;
  always #2.5 i_mclk = ~i_mclk;
  dpa_plant u_dpa_plant (.o_level(lvl), .o_thermo_closed(th), .o_moisture_one(m1), .o_moisture_two(m2));
  dpa_core #(.TICK_CYCLES(T)) u_dpa_core (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_keys(keys), .i_thermo_closed(th), .i_level(lvl),
    .i_moisture_one(m1), .i_moisture_two(m2), .i_scale_low(slo), .i_scale_high(shi),
    .i_alternation_enable(alt), .i_seal_fault_action(sfa), .i_overheat_action(ofa), .i_error_active(err),
    .i_open_secondary(osec), .i_open_secure(osecu), .i_menu_exit(mex), .i_edit_sel(sel), .i_edit_value(val),
    .i_edit_store(est), .i_access_code(code), .i_access_store(ast), .i_pump_one_seal_reset(sr1),
    .i_pump_two_seal_reset(sr2), .i_pump_one_overheat_reset(or1), .i_pump_two_overheat_reset(or2),
    .o_pump_one(p1), .o_pump_two(p2), .o_first_pump_lamp(l1), .o_second_pump_lamp(l2), .o_alarm_high(ah),
    .o_alarm_low(al), .o_seal_lamp(sl), .o_overheat_lamp(ol), .o_seal_fail_show(ss), .o_overheat_fail_show(os),
    .o_access_level_item(lv), .o_menu_state(ms), .o_disp_src(ds), .o_disp_upper(du), .o_disp_lower(dl),
    .o_edit_readback(rb));
  task go(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e)
    begin
      n_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask
  task tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    go(1);
    s = 1'b0;
    go(2);
  endtask
  task pm(input logic [1:0] e);
    chk({p2, p1}, e);
    chk({l2, l1}, e);
  endtask
  task pl(input logic signed [15:0] v, input logic [1:0] e);
    u_dpa_plant.set_level(v);
    go(4);
    pm(e);
  endtask
  task edit(input logic [2:0] s, input logic [15:0] v, input logic [15:0] e);
    sel = s;
    val = v;
    pulse(est);
    chk(rb, e);
  endtask
  task acc(input logic [15:0] c, input logic [2:0] e);
    code = c;
    pulse(ast);
    chk(lv, e);
  endtask
  initial
  begin
    #30000;
    n_errors++;
    tally_and_finish;
  end
  initial
  begin
    go(10);
    i_rst_n = 1'b1;
    go(3);
    chk(lv, 3'h4);
    chk(ms, 3'h1);
    chk(dl, 16'h00E7);
    chk(du, 16'h0028);
    chk(ds, 3'h0);
    err = 1'b1;
    go(2);
    chk(ds, 3'h1);
    err = 1'b0;
    pulse(osec);
    chk(ms, 3'h2);
    edit(3'h0, 16'hFFFB, 16'h0000);
    edit(3'h0, 16'h270F, 16'h012C);
    edit(3'h0, 16'h0064, 16'h0064);
    edit(3'h2, 16'h00C8, 16'h00C8);
    edit(3'h3, 16'h00FA, 16'h00C8);
    edit(3'h3, 16'h0032, 16'h0032);
    edit(3'h1, 16'hFFFB, 16'h0000);
    acc(16'h1101, 3'h2);
    chk(ds, 3'h3);
    go(2 * T);
    chk(ds, 3'h4);
    chk(du, 16'h0002);
    edit(3'h0, 16'h0078, 16'h0064);
    acc(16'h1011, 3'h3);
    acc(16'h1234, 3'h3);
    acc(16'h0111, 3'h4);
    // Pump one counts as stopped last out of reset
    pl(16'sh0096, 2'b10);
    pl(16'sh00D2, 2'b11);
    pl(16'sh0028, 2'b10);
    pl(16'sh0000, 2'b00);
    pl(16'sh0096, 2'b01);
    pl(16'sh0000, 2'b00);
    sfa = 1'b1;
    u_dpa_plant.set_moisture(16'h0014, 16'h0005);
    go(3);
    chk(sl, 2'b10);
    pl(16'sh0096, 2'b01);
    pl(16'sh0000, 2'b00);
    pl(16'sh0096, 2'b01);
    pl(16'sh0000, 2'b00);
    pulse(sr2);
    chk(ss, 2'b10);
    u_dpa_plant.set_moisture(16'h0014, 16'h0014);
    go(3);
    chk(sl, 2'b10);
    pulse(sr2);
    chk(ss, 2'b00);
    chk(sl, 2'b00);
    pl(16'sh0096, 2'b10);
    pl(16'sh0000, 2'b00);
    go(20 * T);
    keys = 4'h1;
    go(6);
    keys = 4'h0;
    go(20 * T);
    chk(ms, 3'h2);
    go(12 * T);
    chk(ms, 3'h1);
    pl(16'sh00FA, 2'b11);
    chk(ah, 1'b1);
    pulse(osecu);
    chk(ms, 3'h4);
    pm(2'b00);
    chk(ah, 1'b0);
    go(58 * T);
    chk(ms, 3'h4);
    go(3 * T);
    chk(ms, 3'h1);
    alt = 1'b0;
    pl(16'sh0000, 2'b00);
    pl(16'sh0096, 2'b01);
    pl(16'sh00D2, 2'b11);
    pl(16'sh0028, 2'b01);
    pl(16'sh0000, 2'b00);
    u_dpa_plant.set_thermo(2'b10);
    go(8);
    pl(16'sh0096, 2'b10);
    chk(ol, 2'b01);
    pl(16'sh0000, 2'b00);
    u_dpa_plant.set_thermo(2'b11);
    go(8);
    chk(ol, 2'b00);
    pl(16'sh0096, 2'b01);
    ofa = 1'b1;
    u_dpa_plant.set_thermo(2'b10);
    go(8);
    pm(2'b10);
    pulse(or1);
    chk(ol, 2'b01);
    u_dpa_plant.set_thermo(2'b11);
    go(8);
    chk(ol, 2'b01);
    chk(os, 2'b01);
    pulse(or1);
    chk(ol, 2'b00);
    chk(p1, 1'b1);
    u_dpa_plant.set_thermo(2'b01);
    go(8);
    pulse(or2);
    chk(ol, 2'b10);
    u_dpa_plant.set_thermo(2'b11);
    go(8);
    pulse(or2);
    chk(ol, 2'b00);
    pl(16'sh0000, 2'b00);
    sfa = 1'b0;
    pl(16'sh0096, 2'b01);
    u_dpa_plant.set_moisture(16'h000B, 16'h0014);
    go(3);
    chk(sl, 2'b01);
    pm(2'b01);
    u_dpa_plant.set_moisture(16'h000C, 16'h0014);
    go(3);
    chk(sl, 2'b00);
    sfa = 1'b1;
    u_dpa_plant.set_moisture(16'h0005, 16'h0014);
    go(3);
    u_dpa_plant.set_moisture(16'h0014, 16'h0014);
    go(3);
    chk(sl, 2'b01);
    pm(2'b01);
    pulse(sr1);
    chk(sl, 2'b00);
    pulse(osec);
    chk(ms, 3'h2);
    pulse(mex);
    chk(ms, 3'h1);
    tally_and_finish;
  end
endmodule // dpa_core_tb
